// *** gpio_port.sv ***
// General purpose I/O port with change notice, remapping and AXI4-Lite.
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "gpio_port_cfg.svh"

// Notes on behaviour
// - direction one is input, zero drives output
// - reset sets every direction bit to input
// - latch reads latch; writes go to latch
// - open drain drives low only, else released
// - analog select resets to all ones
// - analog input pins read zero in state
// - change detection keeps working in sleep
// - edge mode clear: positive enable arms mismatch
// - edge mode: negative falling, positive rising
// - mismatch status: changed since last state read
// - edge mode flag records detected edge
// - separate weak pull up and down enables
// - slew pairs encode slowest, slow, medium, fastest
// - slew registers reset to zero, fastest
// - alias writes touch only bits written one
// - alias reads return undefined data
// - remap peripheral disconnected until assigned
// - remap overrides digital, never analog functions
// - active peripheral replaces latch and direction
// - input selection uses four bit fields
module gpio_port (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // AXI4-Lite write address and data
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // AXI4-Lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Pads
  input wire gpio_port_pkg::pins_t i_pin,
  output gpio_port_pkg::pad_ctrl_s o_pad,
  // Remappable peripherals
  input wire gpio_port_pkg::periph_s i_periph,
  output logic [3:0] o_periph_in,
  // Change notice
  output logic o_cn_irq
);
  import gpio_port_pkg::*;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  pins_t direction_reg;
  pins_t output_latch_reg;
  pins_t open_drain_ctrl;
  pins_t analog_select;
  pins_t change_enable_pos;
  pins_t change_enable_neg;
  pins_t change_status;
  pins_t change_flag;
  pins_t pull_up_enable;
  pins_t pull_down_enable;
  pins_t slew_select_hi;
  pins_t slew_select_lo;
  logic [15:0] change_ctrl;
  logic [15:0] in_select;
  logic [15:0] remap_pin_select;
  pins_t sync_a;
  pins_t sync_b;
  pins_t prev_pin;
  pins_t pin_state_reg;
  logic edge_mode_bit;
  assign edge_mode_bit = change_ctrl[`GP_EDGE_BIT];

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic pins_t alias_apply(input pins_t base,
                                        input pins_t val,
                                        input alias_op_e op);
    unique case (op)
      ALIAS_BASE: alias_apply = val;
      ALIAS_CLR: alias_apply = base & ~val;
      ALIAS_SET: alias_apply = base | val;
      ALIAS_INV: alias_apply = base ^ val;
    endcase
  endfunction

  function automatic logic [15:0] remap_sel_mask(input logic [15:0] sel,
                                                 input logic [3:0] act);
    logic [15:0] m;
    m = 16'h0000;
    for (int k = 0; k < `GP_NREMAP; k++)
    begin
      if (act[k] && sel[k*4 +: 4] != `GP_SEL_NONE)
      begin
        m[sel[k*4 +: 4]] = 1'b1;
      end
    end
    return m;
  endfunction

  // ---------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------
  wr_state_e wr_state;
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic do_write;
  logic [7:0] wr_base;
  alias_op_e wr_op;
  logic wr_hit;
  logic rd_state_hit;

  assign do_write = (wr_state == WR_IDLE) && aw_held && w_held;
  assign wr_base = {aw_addr[7:4], 4'h0};
  assign wr_op = alias_op_e'(aw_addr[3:2]);

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      wr_state <= WR_IDLE;
      o_bvalid <= 1'b0;
      o_bresp <= 2'h0;
    end
    else
    begin
      if (i_awvalid && o_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready)
      begin
        w_held <= 1'b1;
        w_data <= i_wdata;
        o_wready <= 1'b0;
      end
      unique case (wr_state)
        WR_IDLE:
        begin
          if (aw_held && w_held)
          begin
            o_bvalid <= 1'b1;
            o_bresp <= wr_hit ? 2'h0 : 2'h2;
            wr_state <= WR_RESP;
          end
        end
        WR_RESP:
        begin
          if (i_bready)
          begin
            o_bvalid <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            wr_state <= WR_IDLE;
          end
        end
        default: wr_state <= WR_IDLE;
      endcase
    end
  end

  always_comb
  begin
    unique case (wr_base)
      `GP_OFF_DIR, `GP_OFF_STATE, `GP_OFF_LATCH, `GP_OFF_ODC,
      `GP_OFF_ANSEL, `GP_OFF_CNEN, `GP_OFF_CNNE, `GP_OFF_CNSTAT,
      `GP_OFF_CNF, `GP_OFF_CNCON, `GP_OFF_PU, `GP_OFF_PD,
      `GP_OFF_SR1, `GP_OFF_SR0, `GP_OFF_RSEL, `GP_OFF_RMAP: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  function automatic pins_t wr_val(input pins_t base);
    pins_t v;
    v = alias_apply(base, w_data[15:0], wr_op);
    for (int b = 0; b < 2; b++)
    begin
      if (!i_wstrb[b])
      begin
        v[b*8 +: 8] = base[b*8 +: 8];
      end
    end
    return v;
  endfunction

  function automatic logic wr_to(input logic [7:0] off);
    return do_write && (wr_base == off);
  endfunction

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      direction_reg <= `GP_RST_DIR;
      output_latch_reg <= `GP_RST_ZERO;
      open_drain_ctrl <= `GP_RST_ZERO;
      analog_select <= `GP_RST_ANSEL;
      change_enable_pos <= `GP_RST_ZERO;
      change_enable_neg <= `GP_RST_ZERO;
      change_ctrl <= `GP_RST_ZERO;
      pull_up_enable <= `GP_RST_ZERO;
      pull_down_enable <= `GP_RST_ZERO;
      slew_select_hi <= `GP_RST_ZERO;
      slew_select_lo <= `GP_RST_ZERO;
      in_select <= `GP_RST_NONE;
      remap_pin_select <= `GP_RST_NONE;
    end
    else
    begin
      if (wr_to(`GP_OFF_DIR)) direction_reg <= wr_val(direction_reg);
      if (wr_to(`GP_OFF_LATCH))
        output_latch_reg <= wr_val(output_latch_reg);
      else if (wr_to(`GP_OFF_STATE))
        output_latch_reg <= wr_val(output_latch_reg);
      if (wr_to(`GP_OFF_ODC)) open_drain_ctrl <= wr_val(open_drain_ctrl);
      if (wr_to(`GP_OFF_ANSEL)) analog_select <= wr_val(analog_select);
      if (wr_to(`GP_OFF_CNEN))
        change_enable_pos <= wr_val(change_enable_pos);
      if (wr_to(`GP_OFF_CNNE))
        change_enable_neg <= wr_val(change_enable_neg);
      if (wr_to(`GP_OFF_CNCON)) change_ctrl <= wr_val(change_ctrl);
      if (wr_to(`GP_OFF_PU)) pull_up_enable <= wr_val(pull_up_enable);
      if (wr_to(`GP_OFF_PD)) pull_down_enable <= wr_val(pull_down_enable);
      if (wr_to(`GP_OFF_SR1)) slew_select_hi <= wr_val(slew_select_hi);
      if (wr_to(`GP_OFF_SR0)) slew_select_lo <= wr_val(slew_select_lo);
      if (wr_to(`GP_OFF_RSEL)) in_select <= wr_val(in_select);
      if (wr_to(`GP_OFF_RMAP))
        remap_pin_select <= wr_val(remap_pin_select);
    end
  end

  // ---------------------------------------------------------------
  // Input synchroniser and change notice
  // ---------------------------------------------------------------
  pins_t rise;
  pins_t fall;
  pins_t edge_hit;
  pins_t mis_hit;
  assign rise = sync_b & ~prev_pin;
  assign fall = ~sync_b & prev_pin;
  assign edge_hit = (rise & change_enable_pos) | (fall & change_enable_neg);
  assign mis_hit = (sync_b ^ pin_state_reg) & change_enable_pos;

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sync_a <= `GP_RST_ZERO;
      sync_b <= `GP_RST_ZERO;
      prev_pin <= `GP_RST_ZERO;
    end
    else
    begin
      sync_a <= i_pin;
      sync_b <= sync_a;
      prev_pin <= sync_b;
    end
  end

  // Snapshot of the pins at the last read of the state register.
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      pin_state_reg <= `GP_RST_ZERO;
    else if (o_arready && i_arvalid && rd_state_hit)
      pin_state_reg <= sync_b;
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      change_status <= `GP_RST_ZERO;
      change_flag <= `GP_RST_ZERO;
    end
    else
    begin
      if (!edge_mode_bit)
        change_status <= mis_hit;
      else
        change_status <= `GP_RST_ZERO;
      if (wr_to(`GP_OFF_CNF))
        change_flag <= wr_val(change_flag) | (edge_mode_bit ? edge_hit :
                       `GP_RST_ZERO);
      else if (edge_mode_bit)
        change_flag <= change_flag | edge_hit;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
      o_cn_irq <= 1'b0;
    else
      o_cn_irq <= |((change_status | change_flag) &
                    (change_enable_pos | change_enable_neg));
  end

  // ---------------------------------------------------------------
  // Pad control and remapping
  // ---------------------------------------------------------------
  pins_t remap_own;
  pins_t remap_out;
  pins_t remap_oe;
  pad_ctrl_s next_pad;
  logic [3:0] next_periph_in;

  always_comb
  begin
    remap_own = remap_sel_mask(remap_pin_select, i_periph.active);
    remap_out = `GP_RST_ZERO;
    remap_oe = `GP_RST_ZERO;
    for (int k = 0; k < `GP_NREMAP; k++)
    begin
      if (i_periph.active[k] && remap_pin_select[k*4 +: 4] != `GP_SEL_NONE)
      begin
        remap_out[remap_pin_select[k*4 +: 4]] = i_periph.out[k];
        remap_oe[remap_pin_select[k*4 +: 4]] = i_periph.oe[k];
      end
    end
    for (int p = 0; p < `GP_NPINS; p++)
    begin
      logic dval;
      logic den;
      dval = output_latch_reg[p];
      den = ~direction_reg[p];
      if (remap_own[p] && !analog_select[p])
      begin
        dval = remap_out[p];
        den = remap_oe[p];
      end
      if (open_drain_ctrl[p])
      begin
        den = den & ~dval;
        dval = 1'b0;
      end
      next_pad.out[p] = dval;
      next_pad.oe[p] = den;
    end
    next_pad.pull_up = pull_up_enable;
    next_pad.pull_down = pull_down_enable;
    next_pad.analog = analog_select;
    next_pad.slew_hi = slew_select_hi;
    next_pad.slew_lo = slew_select_lo;
    for (int k = 0; k < `GP_NREMAP; k++)
    begin
      next_periph_in[k] = (in_select[k*4 +: 4] == `GP_SEL_NONE) ? 1'b0 :
        sync_b[in_select[k*4 +: 4]] & ~analog_select[in_select[k*4 +: 4]];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_pad <= '0;
      o_periph_in <= 4'h0;
    end
    else
    begin
      o_pad <= next_pad;
      o_periph_in <= next_periph_in;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  logic [15:0] rd_val;
  logic rd_hit;
  assign rd_state_hit = ({i_araddr[7:4], 4'h0} == `GP_OFF_STATE) &&
                        (i_araddr[3:2] == 2'h0);

  always_comb
  begin
    rd_hit = 1'b1;
    unique case ({i_araddr[7:4], 4'h0})
      `GP_OFF_DIR: rd_val = direction_reg;
      `GP_OFF_STATE: rd_val = sync_b & ~analog_select;
      `GP_OFF_LATCH: rd_val = output_latch_reg;
      `GP_OFF_ODC: rd_val = open_drain_ctrl;
      `GP_OFF_ANSEL: rd_val = analog_select;
      `GP_OFF_CNEN: rd_val = change_enable_pos;
      `GP_OFF_CNNE: rd_val = change_enable_neg;
      `GP_OFF_CNSTAT: rd_val = change_status;
      `GP_OFF_CNF: rd_val = change_flag;
      `GP_OFF_CNCON: rd_val = change_ctrl;
      `GP_OFF_PU: rd_val = pull_up_enable;
      `GP_OFF_PD: rd_val = pull_down_enable;
      `GP_OFF_SR1: rd_val = slew_select_hi;
      `GP_OFF_SR0: rd_val = slew_select_lo;
      `GP_OFF_RSEL: rd_val = in_select;
      `GP_OFF_RMAP: rd_val = remap_pin_select;
      default:
      begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= 2'h0;
    end
    else if (o_arready && i_arvalid)
    begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rresp <= rd_hit ? 2'h0 : 2'h2;
      if (i_araddr[3:2] != 2'h0)
        o_rdata <= `GP_UNDEF;
      else
        o_rdata <= {16'h0000, rd_val};
    end
    else if (o_rvalid && i_rready)
    begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end
endmodule // gpio_port

// *** gpio_port_cfg.svh ***
// Register offsets, field positions, reset values and sizes for the port.
`ifndef GPIO_PORT_CFG_SVH
`define GPIO_PORT_CFG_SVH
`define GP_NPINS 16
`define GP_NREMAP 4
`define GP_SEL_W 4
`define GP_OFF_DIR 8'h00
`define GP_OFF_STATE 8'h10
`define GP_OFF_LATCH 8'h20
`define GP_OFF_ODC 8'h30
`define GP_OFF_ANSEL 8'h40
`define GP_OFF_CNEN 8'h50
`define GP_OFF_CNNE 8'h60
`define GP_OFF_CNSTAT 8'h70
`define GP_OFF_CNF 8'h80
`define GP_OFF_CNCON 8'h90
`define GP_OFF_PU 8'hA0
`define GP_OFF_PD 8'hB0
`define GP_OFF_SR1 8'hC0
`define GP_OFF_SR0 8'hD0
`define GP_OFF_RSEL 8'hE0
`define GP_OFF_RMAP 8'hF0
`define GP_EDGE_BIT 11
`define GP_RST_DIR 16'hFFFF
`define GP_RST_ANSEL 16'hFFFF
`define GP_RST_ZERO 16'h0000
`define GP_SEL_NONE 4'hF
`define GP_RST_NONE 16'hFFFF
`define GP_UNDEF 32'h0000_0000
`define GP_SLEW_SLOWEST 2'h3
`define GP_SLEW_SLOW 2'h2
`define GP_SLEW_MEDIUM 2'h1
`define GP_SLEW_FASTEST 2'h0
`endif

// *** gpio_port_pkg.sv ***
// Types shared by the port block.
package gpio_port_pkg;
  typedef logic [15:0] pins_t;
  typedef enum logic [1:0] {ALIAS_BASE, ALIAS_CLR, ALIAS_SET, ALIAS_INV}
    alias_op_e;
  typedef struct packed {
    pins_t out;
    pins_t oe;
    pins_t pull_up;
    pins_t pull_down;
    pins_t analog;
    pins_t slew_hi;
    pins_t slew_lo;
  } pad_ctrl_s;
  typedef struct packed {
    logic [3:0] active;
    logic [3:0] out;
    logic [3:0] oe;
  } periph_s;
  typedef enum logic [1:0] {WR_IDLE, WR_RESP} wr_state_e;
endpackage

// *** gpio_port_asserts.sv ***
// Concurrent checks on the bus handshake and pad outputs of the port.
`timescale 1ns/1ps
`include "gpio_port_cfg.svh"
module gpio_port_asserts (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Write channels
  input wire logic i_awvalid,
  input wire logic o_awready,
  input wire logic i_wvalid,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [1:0] o_bresp,
  // Read channels
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [7:0] i_araddr,
  input wire logic o_rvalid,
  input wire logic [31:0] o_rdata,
  // Pads
  input wire gpio_port_pkg::pad_ctrl_s o_pad
);
  import gpio_port_pkg::*;
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  logic [7:0] rd_addr;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);
  // Remembers the address of the read under way.
  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
      rd_addr <= 8'h00;
    else if (i_arvalid && o_arready)
      rd_addr <= i_araddr;
  sequence aw_w_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence ar_taken;
    i_arvalid && o_arready;
  endsequence
  sequence b_done;
    o_bvalid && i_bready;
  endsequence
  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  reset_pads_a: assert property ($rose(i_rst_b) |=>
    o_pad.oe == 16'h0000 && o_pad.analog == 16'hFFFF &&
    o_pad.slew_hi == 16'h0000 && o_pad.slew_lo == 16'h0000)
    else $error("pads not in reset state");
  wr_answer_a: assert property (aw_w_taken |-> ##[2:3] o_bvalid)
    else $error("write response late");
  rd_answer_a: assert property (ar_taken |-> ##[1:2] o_rvalid)
    else $error("read data late");
  b_stands_a: assert property (o_bvalid && !i_bready |=>
    o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  wr_busy_a: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken during response");
  wr_free_a: assert property (b_done |=> !o_bvalid && o_awready)
    else $error("write channel not freed");
  rd_upper_a: assert property (o_rvalid |-> o_rdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  alias_read_a: assert property (o_rvalid && rd_addr[3:2] != 2'b00 |->
    o_rdata == `GP_UNDEF)
    else $error("alias read not zero");
  analog_zero_a: assert property (o_rvalid && rd_addr == `GP_OFF_STATE |->
    (o_rdata[15:0] & o_pad.analog & ~o_pad.oe) == 16'h0000)
    else $error("analog input read high");
endmodule // gpio_port_asserts
bind gpio_port gpio_port_asserts i_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid),
  .o_wready(o_wready), .o_bvalid(o_bvalid), .i_bready(i_bready),
  .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready),
  .i_araddr(i_araddr), .o_rvalid(o_rvalid), .o_rdata(o_rdata),
  .o_pad(o_pad));

// *** gpio_pins_model.sv ***
// Model of the wiring and devices attached to the port pins.
`timescale 1ns/1ps
module gpio_pins_model (
  // Clock
  input wire logic i_clk,
  // Pad controls and outside drive
  input wire gpio_port_pkg::pad_ctrl_s i_pad,
  input wire gpio_port_pkg::pins_t i_ext_val,
  input wire gpio_port_pkg::pins_t i_ext_en,
  // Resolved levels
  output gpio_port_pkg::pins_t o_pin
);
  import gpio_port_pkg::*;
  pins_t flip = 16'h5555;
  // A pin nobody drives or pulls wanders, so no stale level can be read.
  always @(posedge i_clk)
    flip <= ~flip;
  always_comb
    for (int k = 0; k < 16; k++)
      if (i_pad.oe[k])
        o_pin[k] = i_pad.out[k];
      else if (i_ext_en[k])
        o_pin[k] = i_ext_val[k];
      else if (i_pad.pull_up[k])
        o_pin[k] = 1'b1;
      else if (i_pad.pull_down[k])
        o_pin[k] = 1'b0;
      else
        o_pin[k] = flip[k];
endmodule // gpio_pins_model

// *** tb_top.sv ***
// Self-checking bench for the port block over its register bus.
`timescale 1ns/1ps
`include "gpio_port_cfg.svh"
module tb_top;
  import gpio_port_pkg::*;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_cn_irq;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata, v;
  logic [3:0] o_periph_in;
  pad_ctrl_s o_pad;
  periph_s periph = 12'h000;
  pins_t pin;
  pins_t ext_val = 16'h0000;
  pins_t ext_en = 16'h0000;
  int miscompares = 0;
  int samples_checked = 0;
  always #2.5 i_clk = ~i_clk;
  gpio_port i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_awvalid(awvalid),
    .o_awready(o_awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
    .o_wready(o_wready), .i_wdata(wdata), .i_wstrb(wstrb),
    .o_bvalid(o_bvalid), .i_bready(bready), .o_bresp(o_bresp),
    .i_arvalid(arvalid), .o_arready(o_arready), .i_araddr(araddr),
    .o_rvalid(o_rvalid), .i_rready(rready), .o_rdata(o_rdata),
    .o_rresp(o_rresp), .i_pin(pin), .o_pad(o_pad), .i_periph(periph),
    .o_periph_in(o_periph_in), .o_cn_irq(o_cn_irq));
  gpio_pins_model i_pins (.i_clk(i_clk), .i_pad(o_pad), .i_ext_val(ext_val),
    .i_ext_en(ext_en), .o_pin(pin));
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      miscompares++;
      $display("unexpected at %0t: saw %h wanted %h", $time, s, e);
    end
  endtask
  task automatic give_up(input logic ok);
    if (!ok)
    begin
      miscompares++;
      $display("unexpected at %0t: bus answer missing", $time);
      tally_and_finish;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ha;
    logic hw;
    logic hb;
    logic hv;
    n = 0;
    hb = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!hb && n < 50)
    begin
      @(negedge i_clk);
      ha = awvalid && o_awready;
      hw = wvalid && o_wready;
      hv = o_bvalid;
      hb = hv && bready;
      if (hb)
        chk({30'h0, o_bresp}, 32'h0);
      @(posedge i_clk);
      if (ha)
        awvalid <= 1'b0;
      if (hw)
        wvalid <= 1'b0;
      if (hb)
        bready <= 1'b0;
      else if (hv)
        bready <= 1'b1;
      n++;
    end
    @(posedge i_clk);
    give_up(hb);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    logic ha;
    logic hr;
    n = 0;
    hr = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hr && n < 50)
    begin
      @(negedge i_clk);
      ha = arvalid && o_arready;
      hr = o_rvalid;
      d = o_rdata;
      if (hr)
        chk({30'h0, o_rresp}, 32'h0);
      @(posedge i_clk);
      if (ha)
        arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    @(posedge i_clk);
    give_up(hr);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(d, e);
  endtask
  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    rc(`GP_OFF_DIR, 32'h0000_FFFF);
    rc(`GP_OFF_ANSEL, 32'h0000_FFFF);
    rc(`GP_OFF_SR1, 32'h0000_0000);
    rc(`GP_OFF_SR0, 32'h0000_0000);
    rc(`GP_OFF_RSEL, 32'h0000_FFFF);
    rc(`GP_OFF_RMAP, 32'h0000_FFFF);
    $display("reset test done");
    wr(`GP_OFF_ANSEL, 32'h0);
    wr(`GP_OFF_DIR, 32'h0);
    wr(`GP_OFF_LATCH, 32'hA5A5);
    @(negedge i_clk);
    chk({o_pad.oe, o_pad.out}, 32'hFFFF_A5A5);
    @(posedge i_clk);
    rc(`GP_OFF_LATCH, 32'hA5A5);
    rc(`GP_OFF_STATE, 32'hA5A5);
    wr(`GP_OFF_STATE, 32'h1234);
    rc(`GP_OFF_LATCH, 32'h1234);
    wr(`GP_OFF_ODC, 32'hFFFF);
    @(negedge i_clk);
    chk({o_pad.oe, o_pad.out}, 32'hEDCB_0000);
    @(posedge i_clk);
    wr(`GP_OFF_LATCH + 8'h04, 32'h00FF);
    wr(`GP_OFF_LATCH + 8'h08, 32'h0005);
    wr(`GP_OFF_LATCH + 8'h0C, 32'h1001);
    rc(`GP_OFF_LATCH, 32'h0204);
    rc(`GP_OFF_LATCH + 8'h08, `GP_UNDEF);
    $display("latch test done");
    wr(`GP_OFF_ODC, 32'h0);
    wr(`GP_OFF_DIR + 8'h08, 32'hFFFF);
    wr(`GP_OFF_SR1, 32'h0003);
    wr(`GP_OFF_SR0, 32'h0005);
    wr(`GP_OFF_PU, 32'h00F0);
    wr(`GP_OFF_PD, 32'h0F00);
    @(negedge i_clk);
    chk({o_pad.slew_hi, o_pad.slew_lo}, 32'h0003_0005);
    chk({o_pad.pull_up, o_pad.pull_down}, 32'h00F0_0F00);
    @(posedge i_clk);
    rd(`GP_OFF_STATE, v);
    chk(v & 32'h0FF0, 32'h00F0);
    ext_en <= 16'hFFFF;
    ext_val <= 16'hFFFF;
    wr(`GP_OFF_ANSEL, 32'h00FF);
    rc(`GP_OFF_STATE, 32'hFF00);
    wr(`GP_OFF_ANSEL, 32'h0);
    $display("pad test done");
    wr(`GP_OFF_RSEL, 32'hFFF3);
    @(negedge i_clk);
    chk({28'h0, o_periph_in}, 32'h1);
    @(posedge i_clk);
    ext_val <= 16'hFFF7;
    repeat (4) @(negedge i_clk);
    chk({28'h0, o_periph_in}, 32'h0);
    @(posedge i_clk);
    periph <= 12'h111;
    repeat (2) @(negedge i_clk);
    chk({16'h0, o_pad.oe}, 32'h0);
    @(posedge i_clk);
    wr(`GP_OFF_RMAP, 32'hFFF2);
    @(negedge i_clk);
    chk({30'h0, o_pad.oe[2], o_pad.out[2]}, 32'h3);
    @(posedge i_clk);
    wr(`GP_OFF_ANSEL, 32'h0004);
    @(negedge i_clk);
    chk({31'h0, o_pad.oe[2]}, 32'h0);
    @(posedge i_clk);
    wr(`GP_OFF_ANSEL, 32'h0);
    periph <= 12'h000;
    $display("remap test done");
    ext_val <= 16'h0000;
    wr(`GP_OFF_CNF + 8'h04, 32'hFFFF);
    wr(`GP_OFF_CNEN, 32'h0001);
    rd(`GP_OFF_STATE, v);
    ext_val <= 16'h0001;
    repeat (6) @(posedge i_clk);
    rc(`GP_OFF_CNSTAT, 32'h0001);
    chk({31'h0, o_cn_irq}, 32'h1);
    rd(`GP_OFF_STATE, v);
    rc(`GP_OFF_CNSTAT, 32'h0);
    chk({31'h0, o_cn_irq}, 32'h0);
    wr(`GP_OFF_CNCON, 32'h0800);
    wr(`GP_OFF_CNNE, 32'h0002);
    ext_val <= 16'h0002;
    repeat (6) @(posedge i_clk);
    rc(`GP_OFF_CNF, 32'h0);
    ext_val <= 16'h0001;
    repeat (6) @(posedge i_clk);
    rc(`GP_OFF_CNF, 32'h0003);
    rc(`GP_OFF_CNSTAT, 32'h0);
    chk({31'h0, o_cn_irq}, 32'h1);
    wr(`GP_OFF_CNF + 8'h04, 32'h0003);
    rc(`GP_OFF_CNF, 32'h0);
    chk({31'h0, o_cn_irq}, 32'h0);
    $display("change notice test done");
    tally_and_finish;
  end
endmodule // tb_top
